/* rtl/vxc_device.sv */
// Write-only serial target that programs the eight by six video crosspoint controls.
//
// Implementation choice: the two-wire serial port.
module vxc_device (
  input wire logic I_CLOCK,
  input wire logic I_RST,
  vxc_link_if.device link,
  input wire logic I_ADDR_STRAP_HIGH,
  input wire logic I_ADDR_STRAP_LOW,
  output logic [vxc_pkg::SEL_WIDTH*vxc_pkg::NUM_OUTPUTS-1:0] O_ROUTE_SELECT,
  output logic [vxc_pkg::NUM_OUTPUTS-1:0] O_OUTPUT_POWER_DOWN,
  output logic [vxc_pkg::NUM_INPUTS-1:0] O_CLAMP_SELECT,
  output logic [vxc_pkg::GAIN_WIDTH-1:0] O_GAIN_ZERO_DB
);
  import vxc_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_START,
    ST_BITS,
    ST_ACK,
    ST_IGNORE
  } vxc_dev_state_type;

  typedef enum logic [1:0] {
    PH_ADDR,
    PH_REG,
    PH_DATA
  } vxc_dev_phase_type;

  logic scl_s1, scl_s2, scl_d;
  logic sda_s1, sda_s2, sda_d;
  logic strap_high_s1, strap_high_s2, strap_low_s1, strap_low_s2;
  vxc_dev_state_type state, next_state;
  vxc_dev_phase_type phase, next_phase;
  logic [2:0] bit_cnt, next_bit_cnt;
  logic [7:0] shift, next_shift;
  logic [7:0] reg_ptr, next_reg_ptr;
  logic ack_drive, next_ack_drive;
  logic [7:0] regs [0:4];
  logic [7:0] next_regs [0:4];
  logic [SEL_WIDTH*NUM_OUTPUTS-1:0] next_route;
  logic [NUM_OUTPUTS-1:0] next_pd;
  logic scl_rise, scl_fall, start_seen, stop_seen;
  logic [7:0] own_addr;

  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_d <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_d <= 1'b1;
      strap_high_s1 <= 1'b0;
      strap_high_s2 <= 1'b0;
      strap_low_s1 <= 1'b0;
      strap_low_s2 <= 1'b0;
    end else begin
      scl_s1 <= link.scl_i;
      scl_s2 <= scl_s1;
      scl_d <= scl_s2;
      sda_s1 <= link.sda_i;
      sda_s2 <= sda_s1;
      sda_d <= sda_s2;
      strap_high_s1 <= I_ADDR_STRAP_HIGH;
      strap_high_s2 <= strap_high_s1;
      strap_low_s1 <= I_ADDR_STRAP_LOW;
      strap_low_s2 <= strap_low_s1;
    end
  end

  always_comb begin
    scl_rise = scl_s2 && !scl_d;
    scl_fall = !scl_s2 && scl_d;
    start_seen = scl_s2 && scl_d && sda_d && !sda_s2;
    stop_seen = scl_s2 && scl_d && !sda_d && sda_s2;
    own_addr = DEV_ADDR_BASE;
    own_addr[ADDR_STRAP_HIGH_POS] = strap_high_s2;
    own_addr[ADDR_STRAP_LOW_POS] = strap_low_s2;
  end

  // Protocol state machine.
  always_comb begin
    next_state = state;
    next_phase = phase;
    next_bit_cnt = bit_cnt;
    next_shift = shift;
    next_reg_ptr = reg_ptr;
    next_ack_drive = ack_drive;
    for (int i = 0; i < 5; i++) begin
      next_regs[i] = regs[i];
    end
    if (start_seen) begin
      // A repeated start restarts address matching at any point.
      next_state = ST_START;
      next_phase = PH_ADDR;
      next_bit_cnt = 3'h0;
      next_ack_drive = 1'b0;
    end else if (stop_seen) begin
      next_state = ST_IDLE;
      next_ack_drive = 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          next_ack_drive = 1'b0;
        end
        ST_START: begin
          // The clock fall that closes a start carries no bit, so bit counting waits for it.
          if (scl_fall) begin
            next_state = ST_BITS;
          end
        end
        ST_BITS: begin
          if (scl_rise) begin
            next_shift = {shift[6:0], sda_s2};
          end
          if (scl_fall) begin
            next_bit_cnt = 3'(bit_cnt + 3'h1);
            if (bit_cnt == 3'h7) begin
              if (phase == PH_ADDR && (shift[7:1] != own_addr[7:1] || shift[0])) begin
                next_state = ST_IGNORE;
              end else begin
                next_state = ST_ACK;
                next_ack_drive = 1'b1;
                if (phase == PH_REG) begin
                  next_reg_ptr = shift;
                end
              end
            end
          end
        end
        ST_ACK: begin
          // Released on the falling edge that ends the acknowledge pulse.
          if (scl_fall) begin
            next_ack_drive = 1'b0;
            next_state = ST_BITS;
            next_bit_cnt = 3'h0;
            if (phase == PH_DATA) begin
              if (reg_ptr <= REG_GAIN) begin
                next_regs[reg_ptr[2:0]] = shift;
              end
              next_phase = PH_REG;
            end else if (phase == PH_ADDR) begin
              next_phase = PH_REG;
            end else begin
              next_phase = PH_DATA;
            end
          end
        end
        ST_IGNORE: begin
          next_ack_drive = 1'b0;
        end
        default: begin
          next_state = ST_IDLE;
        end
      endcase
    end
  end

  // Outputs are decoded from the next register values so they land with the update.
  always_comb begin
    for (int o = 0; o < NUM_OUTPUTS; o++) begin
      next_route[SEL_WIDTH*o +: SEL_WIDTH] = next_regs[o/2][4*(o%2) +: 4];
      next_pd[o] = (next_regs[o/2][4*(o%2) +: 4] == 4'h0);
    end
  end

  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      state <= ST_IDLE;
      phase <= PH_ADDR;
      bit_cnt <= 3'h0;
      shift <= 8'h00;
      reg_ptr <= 8'h00;
      ack_drive <= 1'b0;
      for (int i = 0; i < 5; i++) begin
        regs[i] <= REG_RESET_VALUE;
      end
      O_ROUTE_SELECT <= '0;
      O_OUTPUT_POWER_DOWN <= '1;
      O_CLAMP_SELECT <= '0;
      O_GAIN_ZERO_DB <= '0;
    end else begin
      state <= next_state;
      phase <= next_phase;
      bit_cnt <= next_bit_cnt;
      shift <= next_shift;
      reg_ptr <= next_reg_ptr;
      ack_drive <= next_ack_drive;
      for (int i = 0; i < 5; i++) begin
        regs[i] <= next_regs[i];
      end
      O_ROUTE_SELECT <= next_route;
      O_OUTPUT_POWER_DOWN <= next_pd;
      O_CLAMP_SELECT <= next_regs[3];
      O_GAIN_ZERO_DB <= next_regs[4][GAIN_WIDTH-1:0];
    end
  end

  assign link.sda_d_o = 1'b0;
  assign link.sda_d_oe = ack_drive;
endmodule : vxc_device

/* rtl/vxc_link_if.sv */
// Interface carrying the two-wire serial link between the master and the crosspoint.
interface vxc_link_if;
  logic scl_o;
  logic scl_oe;
  logic scl_i;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_d_o;
  logic sda_d_oe;
  logic sda_i;
  // Open drain wire: low whenever an enabled driver pulls low.
  assign scl_i = !(scl_oe && !scl_o);
  assign sda_i = !((sda_m_oe && !sda_m_o) || (sda_d_oe && !sda_d_o));
  modport device (input scl_i, input sda_i, output sda_d_o, output sda_d_oe);
  modport master (input scl_i, input sda_i, output scl_o, output scl_oe, output sda_m_o, output sda_m_oe);
endinterface : vxc_link_if

/* rtl/vxc_master.sv */
// Serial master that writes one crosspoint register per command from a simple host port.
module vxc_master (
  input wire logic I_CLOCK,
  input wire logic I_RST,
  vxc_link_if.master link,
  input wire logic [2:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [7:0] O_RDATA
);
  import vxc_pkg::*;

  typedef enum logic [2:0] {
    MS_IDLE,
    MS_START,
    MS_BIT,
    MS_ACK,
    MS_STOP
  } vxc_mst_state_type;

  vxc_mst_state_type state, next_state;
  logic [7:0] dev_addr, next_dev_addr;
  logic [7:0] reg_addr, next_reg_addr;
  logic [7:0] wdata, next_wdata;
  logic nack, next_nack;
  logic [1:0] quarter, next_quarter;
  logic [7:0] tick_cnt, next_tick_cnt;
  logic [2:0] bit_cnt, next_bit_cnt;
  logic [1:0] byte_idx, next_byte_idx;
  logic scl, next_scl;
  logic sda, next_sda;
  logic [7:0] rdata, next_rdata;
  logic sda_s1, sda_s2;
  logic tick;
  logic [7:0] cur_byte;

  always_comb begin
    tick = (tick_cnt == 8'(SCL_QUARTER_CYCLES - 1));
    case (byte_idx)
      2'h0: cur_byte = {dev_addr[7:1], 1'b0};
      2'h1: cur_byte = reg_addr;
      default: cur_byte = wdata;
    endcase
  end

  always_comb begin
    next_state = state;
    next_dev_addr = dev_addr;
    next_reg_addr = reg_addr;
    next_wdata = wdata;
    next_nack = nack;
    next_quarter = quarter;
    next_tick_cnt = tick ? 8'h00 : 8'(tick_cnt + 8'h01);
    next_bit_cnt = bit_cnt;
    next_byte_idx = byte_idx;
    next_scl = scl;
    next_sda = sda;
    next_rdata = 8'h00;
    if (I_RD) begin
      case (I_ADDR)
        HOST_REG_DEV_ADDR: next_rdata = dev_addr;
        HOST_REG_REG_ADDR: next_rdata = reg_addr;
        HOST_REG_DATA: next_rdata = wdata;
        HOST_REG_STATUS: begin
          next_rdata[STATUS_BUSY_POS] = (state != MS_IDLE);
          next_rdata[STATUS_NACK_POS] = nack;
        end
        default: next_rdata = 8'h00;
      endcase
    end
    if (I_WR && state == MS_IDLE) begin
      case (I_ADDR)
        HOST_REG_DEV_ADDR: next_dev_addr = I_WDATA;
        HOST_REG_REG_ADDR: next_reg_addr = I_WDATA;
        HOST_REG_DATA: next_wdata = I_WDATA;
        HOST_REG_CTRL: begin
          // Start only with its own clock and data released and the sampled bus data line high; the bus clock line is not read.
          if (I_WDATA[0] && scl && sda && sda_s2) begin
            next_state = MS_START;
            next_nack = 1'b0;
            next_quarter = 2'h0;
            next_tick_cnt = 8'h00;
            next_byte_idx = 2'h0;
            next_bit_cnt = 3'h0;
          end
        end
        default: begin
        end
      endcase
    end else if (tick) begin
      next_quarter = 2'(quarter + 2'h1);
      case (state)
        MS_IDLE: begin
          next_quarter = 2'h0;
        end
        MS_START: begin
          if (quarter == 2'h1) next_sda = 1'b0;
          if (quarter == 2'h3) begin
            next_scl = 1'b0;
            next_state = MS_BIT;
          end
        end
        MS_BIT, MS_ACK: begin
          // Data changes only in the low half, one bit per pulse.
          if (quarter == 2'h0) next_sda = (state == MS_ACK) ? 1'b1 : cur_byte[3'(7 - bit_cnt)];
          if (quarter == 2'h1) next_scl = 1'b1;
          if (quarter == 2'h2 && state == MS_ACK && sda_s2) next_nack = 1'b1;
          if (quarter == 2'h3) begin
            next_scl = 1'b0;
            if (state == MS_BIT) begin
              next_bit_cnt = 3'(bit_cnt + 3'h1);
              if (bit_cnt == 3'h7) next_state = MS_ACK;
            end else if (byte_idx == 2'h2 || nack) begin
              next_state = MS_STOP;
            end else begin
              next_byte_idx = 2'(byte_idx + 2'h1);
              next_state = MS_BIT;
            end
          end
        end
        MS_STOP: begin
          if (quarter == 2'h0) next_sda = 1'b0;
          if (quarter == 2'h1) next_scl = 1'b1;
          if (quarter == 2'h2) next_sda = 1'b1;
          if (quarter == 2'h3) next_state = MS_IDLE;
        end
        default: begin
          next_state = MS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      state <= MS_IDLE;
      dev_addr <= DEV_ADDR_BASE;
      reg_addr <= 8'h00;
      wdata <= 8'h00;
      nack <= 1'b0;
      quarter <= 2'h0;
      tick_cnt <= 8'h00;
      bit_cnt <= 3'h0;
      byte_idx <= 2'h0;
      scl <= 1'b1;
      sda <= 1'b1;
      rdata <= 8'h00;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
    end else begin
      state <= next_state;
      dev_addr <= next_dev_addr;
      reg_addr <= next_reg_addr;
      wdata <= next_wdata;
      nack <= next_nack;
      quarter <= next_quarter;
      tick_cnt <= next_tick_cnt;
      bit_cnt <= next_bit_cnt;
      byte_idx <= next_byte_idx;
      scl <= next_scl;
      sda <= next_sda;
      rdata <= next_rdata;
      sda_s1 <= link.sda_i;
      sda_s2 <= sda_s1;
    end
  end

  // Open drain: drive only lows, release for highs.
  assign link.scl_o = 1'b0;
  assign link.scl_oe = !scl;
  assign link.sda_m_o = 1'b0;
  assign link.sda_m_oe = !sda;
  assign O_RDATA = rdata;
endmodule : vxc_master

/* rtl/vxc_pkg.sv */
// Package of constants shared by both ends of the crosspoint control link.
package vxc_pkg;
  localparam logic [7:0] DEV_ADDR_BASE = 8'h06;
  localparam int ADDR_STRAP_HIGH_POS = 7;
  localparam int ADDR_STRAP_LOW_POS = 6;
  localparam logic [7:0] REG_ROUTE_ONE_TWO = 8'h00;
  localparam logic [7:0] REG_ROUTE_THREE_FOUR = 8'h01;
  localparam logic [7:0] REG_ROUTE_FIVE_SIX = 8'h02;
  localparam logic [7:0] REG_CLAMP_BIAS = 8'h03;
  localparam logic [7:0] REG_GAIN = 8'h04;
  localparam logic [7:0] REG_RESET_VALUE = 8'h00;
  localparam int NUM_OUTPUTS = 6;
  localparam int NUM_INPUTS = 8;
  localparam int SEL_WIDTH = 4;
  localparam int GAIN_WIDTH = 6;
  // Master timing: the serial clock is 100 kHz at a 10 MHz system clock.
  localparam int CLK_FREQ_HZ = 10000000;
  localparam int SCL_FREQ_HZ = 100000;
  localparam int SCL_QUARTER_CYCLES = CLK_FREQ_HZ / SCL_FREQ_HZ / 4;
  // Host command port register map.
  localparam logic [2:0] HOST_REG_DEV_ADDR = 3'h0;
  localparam logic [2:0] HOST_REG_REG_ADDR = 3'h1;
  localparam logic [2:0] HOST_REG_DATA = 3'h2;
  localparam logic [2:0] HOST_REG_CTRL = 3'h3;
  localparam logic [2:0] HOST_REG_STATUS = 3'h4;
  localparam int STATUS_BUSY_POS = 0;
  localparam int STATUS_NACK_POS = 1;
endpackage : vxc_pkg

/* verif/tb_video_crosspoint_i2c_ctrl.sv */
// Bench: host port drives the master; a second device is driven by a hand-made bus master.
module tb_video_crosspoint_i2c_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  import vxc_pkg::*;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'h0;
  logic rd = 1'h0;
  logic strap_h = 1'h0;
  logic strap_l = 1'h0;
  logic [7:0] rdata;
  logic [23:0] route;
  logic [5:0] pd;
  logic [7:0] clamp;
  logic [5:0] gain;
  logic [7:0] clamp_b;
  logic [5:0] gain_b;
  logic [7:0] m [0:4] = '{default: 8'h00};
  int n_mismatch = 0;
  int checked = 0;
  int cycles = 0;
  vxc_link_if link ();
  vxc_link_if link_b ();
  vxc_master vxc_master_inst (.I_CLOCK(clk), .I_RST(rst), .link(link.master), .I_ADDR(addr), .I_WDATA(wdata),
    .I_WR(wr), .I_RD(rd), .O_RDATA(rdata));
  vxc_device vxc_device_inst (.I_CLOCK(clk), .I_RST(rst), .link(link.device), .I_ADDR_STRAP_HIGH(strap_h),
    .I_ADDR_STRAP_LOW(strap_l), .O_ROUTE_SELECT(route), .O_OUTPUT_POWER_DOWN(pd), .O_CLAMP_SELECT(clamp),
    .O_GAIN_ZERO_DB(gain));
  vxc_device vxc_device_inst_b (.I_CLOCK(clk), .I_RST(rst), .link(link_b.device), .I_ADDR_STRAP_HIGH(1'h0),
    .I_ADDR_STRAP_LOW(1'h0), .O_ROUTE_SELECT(), .O_OUTPUT_POWER_DOWN(), .O_CLAMP_SELECT(clamp_b),
    .O_GAIN_ZERO_DB(gain_b));
  vxc_link_sva vxc_link_sva_inst (.I_CLOCK(clk), .I_RST(rst), .scl_i(link.scl_i), .sda_i(link.sda_i),
    .sda_d_o(link.sda_d_o), .sda_d_oe(link.sda_d_oe));
  always #50 clk = ~clk;
  // About sixteen transfers of some three thousand cycles each fit well below this ceiling.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 90000) begin
      n_mismatch++;
      results();
    end
  end
  task results;
    $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : results
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %s expected %0h seen %0h", name, exp, got);
    end
  endtask : chk
  task host_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
  endtask : host_wr
  task host_rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
    #1 d = rdata;
  endtask : host_rd
  task xfer(input logic [7:0] dev, input logic [7:0] ra, input logic [7:0] d, input logic exp_nack);
    logic [7:0] st;
    int n;
    host_wr(HOST_REG_DEV_ADDR, dev);
    host_wr(HOST_REG_REG_ADDR, ra);
    host_wr(HOST_REG_DATA, d);
    host_rd(HOST_REG_DEV_ADDR, st);
    chk("dev_rb", 32'(dev), 32'(st));
    host_rd(HOST_REG_REG_ADDR, st);
    chk("reg_rb", 32'(ra), 32'(st));
    host_rd(HOST_REG_DATA, st);
    chk("data_rb", 32'(d), 32'(st));
    host_wr(HOST_REG_CTRL, 8'h01);
    host_rd(HOST_REG_STATUS, st);
    chk("busy", 32'h1, 32'(st[STATUS_BUSY_POS]));
    n = 0;
    while (st[STATUS_BUSY_POS] !== 1'h0 && n < 2000) begin
      repeat (8) @(posedge clk);
      host_rd(HOST_REG_STATUS, st);
      n++;
    end
    chk("nack", 32'(exp_nack), 32'(st[STATUS_NACK_POS]));
    if (!exp_nack && ra <= REG_GAIN) m[ra[2:0]] = d;
    repeat (5) @(posedge clk);
  endtask : xfer
  task check_outs;
    logic [23:0] r;
    logic [5:0] p;
    r = {m[2], m[1], m[0]};
    for (int k = 0; k < NUM_OUTPUTS; k++) p[k] = (r[SEL_WIDTH*k +: SEL_WIDTH] == 4'h0);
    chk("route", 32'(r), 32'(route));
    chk("power_down", 32'(p), 32'(pd));
    chk("clamp", 32'(m[3]), 32'(clamp));
    chk("gain", 32'(m[4][5:0]), 32'(gain));
  endtask : check_outs
  // Two clocks per quarter give the 800 ns link clock that the bench drives on the second link.
  task half;
    repeat (2) @(posedge clk);
  endtask : half
  task bb_bit(input logic b, output logic s);
    link_b.sda_m_oe <= !b;
    half();
    link_b.scl_oe <= 1'h0;
    half();
    #1 s = link_b.sda_i;
    half();
    link_b.scl_oe <= 1'h1;
    half();
  endtask : bb_bit
  task bb_byte(input logic [7:0] b, output logic a);
    logic s;
    for (int i = 7; i >= 0; i--) bb_bit(b[i], s);
    bb_bit(1'h1, s);
    a = !s;
  endtask : bb_byte
  task bb_start;
    half();
    link_b.sda_m_oe <= 1'h1;
    half();
    link_b.scl_oe <= 1'h1;
    half();
  endtask : bb_start
  task bb_stop;
    link_b.sda_m_oe <= 1'h1;
    half();
    link_b.scl_oe <= 1'h0;
    half();
    link_b.sda_m_oe <= 1'h0;
    half();
  endtask : bb_stop
  task t_straps;
    logic [7:0] dev;
    logic [7:0] d;
    for (int i = 0; i < 4; i++) begin
      strap_h <= i[1];
      strap_l <= i[0];
      dev = DEV_ADDR_BASE | 8'(i << 6);
      d = 8'(((i + 1) << 4) | (8 - i));
      repeat (5) @(posedge clk);
      xfer(dev ^ 8'h40, REG_ROUTE_ONE_TWO, 8'h77, 1'h1);
      xfer(dev, REG_ROUTE_ONE_TWO, d, 1'h0);
      check_outs();
    end
    strap_h <= 1'h0;
    strap_l <= 1'h0;
    repeat (5) @(posedge clk);
    $display("test straps finished");
  endtask : t_straps
  task t_route;
    xfer(DEV_ADDR_BASE, REG_ROUTE_THREE_FOUR, 8'h11, 1'h0);
    xfer(DEV_ADDR_BASE, REG_ROUTE_FIVE_SIX, 8'h80, 1'h0);
    check_outs();
    xfer(DEV_ADDR_BASE, REG_ROUTE_ONE_TWO, 8'h00, 1'h0);
    check_outs();
    $display("test route finished");
  endtask : t_route
  task t_regs;
    xfer(DEV_ADDR_BASE, REG_CLAMP_BIAS, 8'hA5, 1'h0);
    xfer(DEV_ADDR_BASE, REG_ROUTE_THREE_FOUR, 8'h23, 1'h0);
    check_outs();
    xfer(DEV_ADDR_BASE, REG_GAIN, 8'hFF, 1'h0);
    check_outs();
    xfer(DEV_ADDR_BASE, 8'h05, 8'hFF, 1'h0);
    xfer(DEV_ADDR_BASE, 8'hFF, 8'h12, 1'h0);
    check_outs();
    $display("test registers finished");
  endtask : t_regs
  task t_far;
    logic [4:0] a;
    bb_start();
    bb_byte(DEV_ADDR_BASE | 8'h01, a[0]);
    bb_stop();
    chk("read_ack", 32'h0, 32'(a[0]));
    bb_start();
    bb_byte(DEV_ADDR_BASE, a[4]);
    bb_byte(REG_GAIN, a[3]);
    bb_byte(8'h15, a[2]);
    bb_byte(REG_CLAMP_BIAS, a[1]);
    bb_byte(8'h3C, a[0]);
    bb_stop();
    repeat (5) @(posedge clk);
    chk("acks", 32'h1F, 32'(a));
    chk("gain_b", 32'h15, 32'(gain_b));
    chk("clamp_b", 32'h3C, 32'(clamp_b));
    $display("test far end finished");
  endtask : t_far
  initial begin
    link_b.scl_o = 1'h0;
    link_b.scl_oe = 1'h0;
    link_b.sda_m_o = 1'h0;
    link_b.sda_m_oe = 1'h0;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    check_outs();
    $display("test reset finished");
    t_straps();
    t_route();
    t_regs();
    t_far();
    results();
  end
endmodule : tb_video_crosspoint_i2c_ctrl

/* verif/vxc_link_sva.sv */
// Concurrent checks on the serial link between the master and the crosspoint device.
module vxc_link_sva (
  input wire logic I_CLOCK,
  input wire logic I_RST,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_d_o,
  input wire logic sda_d_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic scl_q;
  logic sda_q;
  logic [3:0] bit_cnt;
  logic [3:0] next_bit_cnt;
  logic [15:0] phase_cnt;
  logic [15:0] next_phase_cnt;
  logic start_seen;
  logic stop_seen;
  assign start_seen = scl_i && scl_q && sda_q && !sda_i;
  assign stop_seen = scl_i && scl_q && !sda_q && sda_i;
  // The stop's own clock rise follows the acknowledge pulse, so a whole byte leaves the count at one.
  always_comb begin
    next_bit_cnt = bit_cnt;
    if (start_seen) begin
      next_bit_cnt = 4'h0;
    end else if (scl_i && !scl_q) begin
      next_bit_cnt = (bit_cnt == 4'h8) ? 4'h0 : bit_cnt + 4'h1;
    end
    next_phase_cnt = (phase_cnt == 16'hFFFF) ? phase_cnt : phase_cnt + 16'h0001;
    if (scl_i != scl_q) begin
      next_phase_cnt = 16'h0001;
    end
  end
  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      scl_q <= 1'h1;
      sda_q <= 1'h1;
      bit_cnt <= 4'h0;
      phase_cnt <= 16'h0000;
    end else begin
      scl_q <= scl_i;
      sda_q <= sda_i;
      bit_cnt <= next_bit_cnt;
      phase_cnt <= next_phase_cnt;
    end
  end
  default clocking cb @(posedge I_CLOCK);
  endclocking
  default disable iff (I_RST);
  sequence s_ack_rise;
    scl_i && !scl_q && sda_d_oe;
  endsequence
  sequence s_ack_fall;
    !scl_i && scl_q && sda_d_oe;
  endsequence
  a_ack_low_only: assert property (sda_d_oe |-> !sda_d_o)
    else $error("device drives the data line high");
  a_ack_ninth_pulse: assert property (s_ack_rise |-> bit_cnt == 4'h8)
    else $error("device acknowledge outside the ninth pulse");
  a_ack_held_high: assert property (s_ack_rise |-> (sda_d_oe && !sda_i) [*8])
    else $error("acknowledge not held low while clock high");
  a_ack_release: assert property (s_ack_fall |-> ##[1:8] !sda_d_oe)
    else $error("device keeps data line after acknowledge");
  a_dev_stable_high: assert property (scl_i && scl_q |-> $stable(sda_d_oe))
    else $error("device changes data line while clock high");
  a_stop_whole_byte: assert property (stop_seen |-> bit_cnt == 4'h1)
    else $error("stop not after a whole acknowledged byte");
  a_start_idle_bus: assert property (start_seen |-> $past(scl_i, 8) && $past(sda_i, 8))
    else $error("start without idle bus");
  a_scl_high_min: assert property (!scl_i && scl_q |-> phase_cnt >= 16'h0026)
    else $error("clock high phase too short");
  a_scl_low_min: assert property (scl_i && !scl_q |-> phase_cnt >= 16'h002D)
    else $error("clock low phase too short");
endmodule : vxc_link_sva
